/* logic/alcb_pkg.sv */
// Purpose: Shared constants for the address latch and command buffer block
// Assumes: 100 MHz single clock, AHB-Lite register access
// Notes:   Offsets are byte addresses of 32-bit words
package alcb_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_MS     = 1000;
    localparam int unsigned SECOND_CYC    = SECOND_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned SEC_PER_MIN   = 60;
    localparam int unsigned CMOS_BYTES    = 128;

    localparam logic [7:0] OFS_INDEX  = 8'h00;
    localparam logic [7:0] OFS_DATA   = 8'h04;
    localparam logic [7:0] OFS_CTRL   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CS0    = 8'h10;
    localparam logic [7:0] OFS_CS1    = 8'h14;
    localparam logic [7:0] OFS_CS2    = 8'h18;
    localparam logic [7:0] OFS_MCPORT = 8'h1c;

    // Control register fields
    localparam int unsigned CTRL_MODE_LO = 0;
    localparam int unsigned CTRL_IRQ_EN  = 2;
    localparam int unsigned CTRL_CS_LO   = 3;
    // Status register fields
    localparam int unsigned ST_TEST   = 0;
    localparam int unsigned ST_MINUTE = 1;
    localparam int unsigned ST_MASTER = 2;

    localparam logic [7:0]  INDEX_RST  = 8'h80;
    localparam logic [5:0]  CTRL_RST   = 6'h00;
    localparam logic [23:0] CS_RST     = 24'h000000;
    localparam logic [23:0] MCPORT_RST = 24'h000022;
    localparam logic [3:0]  LOWMEG_TOP = 4'h0;

    typedef enum logic [1:0] {
        ALCB_SYNC_HALF,
        ALCB_SYNC_QUARTER,
        ALCB_ASYNC
    } alcb_mode_e;
endpackage

/* logic/alcb_top.sv */
// Purpose: Address latch, command buffers, clock/CMOS store and I/O selects
// Assumes: All pins synchronous to clock; strobe held high at least one cycle
// Notes:   Latch outputs lag the CPU address by one cycle (all outputs flopped)
//
// Behaviour
// - Low channel address follows CPU address while strobe high, holds after fall.
// - Mid channel address bits behave like the low bits under the strobe.
// - Internal address bits 0-23 captured at strobe falling edge.
// - Upper address passes in half-rate sync mode, else captured at strobe fall.
// - Channel byte-high-enable latches CPU one under the strobe; in master mode it drives CPU side.
// - Low-megabyte memory commands asserted only for addresses below 1M.
// - Address enable high during DMA; I/O selects then deselected.
// - Memory-address transceiver enable asserted for accesses to controller port.
// - Test mode while master request and both channel I/O commands low.
// - Minute pulse output derived from the clock's minute counter.
// - Clock interrupt request driven when the clock needs service.
// - 128 CMOS bytes; no frequency select input, no square wave output.
// - Three active-low I/O selects, each matching its programmed address.
// - Index register selects CMOS byte, bit 7 disables NMI; data port accesses.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module alcb_top #(
    parameter int unsigned SECOND_CYCLES = alcb_pkg::SECOND_CYC
) (
    input  wire logic        clock,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // CPU side
    input  wire logic [23:0] cpuAddrIn,
    output logic      [23:0] cpuAddrOut,
    output logic             cpuAddrOe,
    input  wire logic        addressBitTwenty,
    input  wire logic        cpuByteHighEnableInN,
    output logic             cpuByteHighEnableOutN,
    output logic             cpuByteHighEnableOe,
    input  wire logic        cpuIoReadN,
    input  wire logic        cpuIoWriteN,
    input  wire logic        cpuMemReadN,
    input  wire logic        cpuMemWriteN,
    output logic      [3:0]  cpuCmdOutN,
    output logic             cpuCmdOe,
    // Controls from system controller
    input  wire logic        addrLatchStrobe,
    input  wire logic        commandBufferEnableN,
    input  wire logic        addressEnable,
    // Channel side
    input  wire logic [16:0] channelAddrLowIn,
    output logic      [16:0] channelLatchedAddressLow,
    output logic             channelAddrLowOe,
    output logic      [2:0]  channelLatchedAddressMid,
    output logic      [6:0]  upperUnlatchedAddress,
    input  wire logic        channelByteHighEnableInN,
    output logic             channelByteHighEnableOutN,
    output logic             channelByteHighEnableOe,
    input  wire logic        masterRequestN,
    input  wire logic        channelIoReadInN,
    input  wire logic        channelIoWriteInN,
    output logic             channelIoReadOutN,
    output logic             channelIoWriteOutN,
    output logic             channelIoOe,
    output logic             lowmegChannelMemReadN,
    output logic             lowmegChannelMemWriteN,
    // Miscellaneous
    output logic             memaddrTransceiverEnableN,
    output logic             minutePulseOut,
    output logic             clockInterruptRequest,
    output logic             nmiDisable,
    output logic             testMode,
    output logic      [2:0]  progIoSelectN
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  index_r;
    logic [5:0]  ctrl_r;
    logic [23:0] csBase_r [3];
    logic [23:0] mcPort_r;
    logic [7:0]  cmos_r [alcb_pkg::CMOS_BYTES];
    logic        minuteFlag_r;
    logic        wrPend_r;
    logic [7:0]  wrAddr_r;
    logic        aleDly_r;
    logic [23:0] intAddr_r;
    logic [31:0] secCnt_r;
    logic [5:0]  minCnt_r;
    logic        minuteEv;
    logic        aleFall;
    logic        masterMode;
    logic        ioCycle;
    logic [23:0] fullAddr;
    logic        addrPhase;
    logic [31:0] rdVal;
    alcb_pkg::alcb_mode_e mode;

    assign mode       = alcb_pkg::alcb_mode_e'(ctrl_r[alcb_pkg::CTRL_MODE_LO +: 2]);
    assign masterMode = ~masterRequestN;
    assign aleFall    = aleDly_r & ~addrLatchStrobe;
    // Bit twenty is taken as gated upstream, never re-gated here
    assign fullAddr   = {cpuAddrIn[23:21], addressBitTwenty, cpuAddrIn[19:0]};
    assign ioCycle    = ~cpuIoReadN | ~cpuIoWriteN;
    assign addrPhase  = hsel & hready & htrans[1];

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: reads answered with zero wait, writes land in data phase
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wrPend_r  <= 1'b0;
            wrAddr_r  <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_r  <= addrPhase & hwrite;
            wrAddr_r  <= haddr;
            if (addrPhase & ~hwrite)
            begin
                hrdata <= rdVal;
            end
        end
    end

    always_comb
    begin
        rdVal = 32'h00000000;
        unique case (haddr)
            alcb_pkg::OFS_INDEX:  rdVal[7:0]  = index_r;
            alcb_pkg::OFS_DATA:   rdVal[7:0]  = cmos_r[index_r[6:0]];
            alcb_pkg::OFS_CTRL:   rdVal[5:0]  = ctrl_r;
            alcb_pkg::OFS_STATUS: rdVal[2:0]  = {masterMode, minuteFlag_r, testMode};
            alcb_pkg::OFS_CS0:    rdVal[23:0] = csBase_r[0];
            alcb_pkg::OFS_CS1:    rdVal[23:0] = csBase_r[1];
            alcb_pkg::OFS_CS2:    rdVal[23:0] = csBase_r[2];
            alcb_pkg::OFS_MCPORT: rdVal[23:0] = mcPort_r;
            default:              rdVal       = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            index_r     <= alcb_pkg::INDEX_RST;
            ctrl_r      <= alcb_pkg::CTRL_RST;
            csBase_r[0] <= alcb_pkg::CS_RST;
            csBase_r[1] <= alcb_pkg::CS_RST;
            csBase_r[2] <= alcb_pkg::CS_RST;
            mcPort_r    <= alcb_pkg::MCPORT_RST;
        end
        else if (wrPend_r)
        begin
            unique case (wrAddr_r)
                alcb_pkg::OFS_INDEX:  index_r     <= hwdata[7:0];
                alcb_pkg::OFS_CTRL:   ctrl_r      <= hwdata[5:0];
                alcb_pkg::OFS_CS0:    csBase_r[0] <= hwdata[23:0];
                alcb_pkg::OFS_CS1:    csBase_r[1] <= hwdata[23:0];
                alcb_pkg::OFS_CS2:    csBase_r[2] <= hwdata[23:0];
                alcb_pkg::OFS_MCPORT: mcPort_r    <= hwdata[23:0];
                default:              ;
            endcase
        end
    end

    // Battery-backed store: no reset, contents survive system reset
    always_ff @(posedge clock)
    begin
        if (wrPend_r && wrAddr_r == alcb_pkg::OFS_DATA)
        begin
            cmos_r[index_r[6:0]] <= hwdata[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            nmiDisable <= 1'b1;
        end
        else
        begin
            nmiDisable <= index_r[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address latch
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            aleDly_r  <= 1'b0;
            intAddr_r <= 24'h000000;
        end
        else
        begin
            aleDly_r <= addrLatchStrobe;
            if (addrLatchStrobe)
            begin
                intAddr_r <= fullAddr;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            channelLatchedAddressLow <= 17'h00000;
            channelLatchedAddressMid <= 3'h0;
            upperUnlatchedAddress    <= 7'h00;
        end
        else
        begin
            if (addrLatchStrobe)
            begin
                channelLatchedAddressLow <= fullAddr[16:0];
                channelLatchedAddressMid <= fullAddr[19:17];
            end
            if (mode == alcb_pkg::ALCB_SYNC_HALF || addrLatchStrobe)
            begin
                upperUnlatchedAddress <= fullAddr[23:17];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Direction and commands; master mode turns the buffers round
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            channelAddrLowOe          <= 1'b1;
            cpuAddrOe                 <= 1'b0;
            cpuAddrOut                <= 24'h000000;
            channelByteHighEnableOe   <= 1'b1;
            channelByteHighEnableOutN <= 1'b1;
            cpuByteHighEnableOe       <= 1'b0;
            cpuByteHighEnableOutN     <= 1'b1;
            cpuCmdOe                  <= 1'b0;
            cpuCmdOutN                <= 4'hf;
            channelIoOe               <= 1'b0;
            channelIoReadOutN         <= 1'b1;
            channelIoWriteOutN        <= 1'b1;
            lowmegChannelMemReadN     <= 1'b1;
            lowmegChannelMemWriteN    <= 1'b1;
        end
        else
        begin
            channelAddrLowOe        <= ~masterMode;
            cpuAddrOe               <= masterMode;
            cpuAddrOut              <= {7'h00, channelAddrLowIn};
            channelByteHighEnableOe <= ~masterMode;
            cpuByteHighEnableOe     <= masterMode;
            cpuByteHighEnableOutN   <= channelByteHighEnableInN;
            if (addrLatchStrobe)
            begin
                channelByteHighEnableOutN <= cpuByteHighEnableInN;
            end
            cpuCmdOe           <= masterMode;
            cpuCmdOutN         <= {channelIoReadInN, channelIoWriteInN, 2'b11};
            // The buffer enable is trusted as given
            channelIoOe        <= ~masterMode & ~commandBufferEnableN;
            channelIoReadOutN  <= cpuIoReadN;
            channelIoWriteOutN <= cpuIoWriteN;
            // Below 1M only
            lowmegChannelMemReadN  <= ~(~commandBufferEnableN & ~cpuMemReadN &
                                        intAddr_r[23:20] == alcb_pkg::LOWMEG_TOP);
            lowmegChannelMemWriteN <= ~(~commandBufferEnableN & ~cpuMemWriteN &
                                        intAddr_r[23:20] == alcb_pkg::LOWMEG_TOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Chip selects and test entry; DMA cycles never select
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            progIoSelectN             <= 3'b111;
            memaddrTransceiverEnableN <= 1'b1;
            testMode                  <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                progIoSelectN[i] <= ~(ioCycle & ~addressEnable &
                                      ctrl_r[alcb_pkg::CTRL_CS_LO + i] &
                                      intAddr_r == csBase_r[i]);
            end
            memaddrTransceiverEnableN <= ~(ioCycle & ~addressEnable &
                                           intAddr_r == mcPort_r);
            testMode <= masterMode & ~channelIoReadInN & ~channelIoWriteInN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Seconds divider and minute counter
    assign minuteEv = (secCnt_r == SECOND_CYCLES - 1) &&
                      (minCnt_r == 6'(alcb_pkg::SEC_PER_MIN - 1));

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            secCnt_r       <= 32'h00000000;
            minCnt_r       <= 6'h00;
            minutePulseOut <= 1'b0;
        end
        else
        begin
            secCnt_r       <= (secCnt_r == SECOND_CYCLES - 1) ? 32'h00000000 : secCnt_r + 32'h00000001;
            minutePulseOut <= minuteEv;
            if (secCnt_r == SECOND_CYCLES - 1)
            begin
                minCnt_r <= minuteEv ? 6'h00 : minCnt_r + 6'h01;
            end
        end
    end

    // Sticky minute flag; a new minute beats a simultaneous clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            minuteFlag_r          <= 1'b0;
            clockInterruptRequest <= 1'b0;
        end
        else
        begin
            if (minuteEv)
            begin
                minuteFlag_r <= 1'b1;
            end
            else if (wrPend_r && wrAddr_r == alcb_pkg::OFS_STATUS && hwdata[alcb_pkg::ST_MINUTE])
            begin
                minuteFlag_r <= 1'b0;
            end
            clockInterruptRequest <= minuteFlag_r & ctrl_r[alcb_pkg::CTRL_IRQ_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_strobeFall;
        aleFall;
    endsequence

    property p_lowHold;
        @(posedge clock) disable iff (rst)
        s_strobeFall ##1 !addrLatchStrobe |-> $stable(channelLatchedAddressLow);
    endproperty
    a_lowHold: assert property (p_lowHold) else $error("low address moved while latched");

    property p_lowFollow;
        @(posedge clock) disable iff (rst)
        addrLatchStrobe |=> channelLatchedAddressLow == $past(fullAddr[16:0]);
    endproperty
    a_lowFollow: assert property (p_lowFollow) else $error("low address not transparent");

    property p_midHold;
        @(posedge clock) disable iff (rst)
        s_strobeFall ##1 !addrLatchStrobe |-> $stable(channelLatchedAddressMid);
    endproperty
    a_midHold: assert property (p_midHold) else $error("mid address moved while latched");

    property p_upperLatch;
        @(posedge clock) disable iff (rst)
        !addrLatchStrobe && mode != alcb_pkg::ALCB_SYNC_HALF |=> $stable(upperUnlatchedAddress);
    endproperty
    a_upperLatch: assert property (p_upperLatch) else $error("upper address not held");

    property p_lowmeg;
        @(posedge clock) disable iff (rst)
        !lowmegChannelMemReadN || !lowmegChannelMemWriteN |-> $past(intAddr_r[23:20]) == 4'h0;
    endproperty
    a_lowmeg: assert property (p_lowmeg) else $error("memory command above 1M");

    property p_dmaDeselect;
        @(posedge clock) disable iff (rst)
        addressEnable |=> progIoSelectN == 3'b111;
    endproperty
    a_dmaDeselect: assert property (p_dmaDeselect) else $error("select during DMA");

    property p_test;
        @(posedge clock) disable iff (rst)
        !masterRequestN && !channelIoReadInN && !channelIoWriteInN |=> testMode;
    endproperty
    a_test: assert property (p_test) else $error("test mode not entered");

    property p_reverse;
        @(posedge clock) disable iff (rst)
        !masterRequestN |=> cpuAddrOe && !channelAddrLowOe && !channelByteHighEnableOe;
    endproperty
    a_reverse: assert property (p_reverse) else $error("buffers not reversed");

    property p_irq;
        @(posedge clock) disable iff (rst)
        minuteEv ##1 ctrl_r[alcb_pkg::CTRL_IRQ_EN] |=> clockInterruptRequest;
    endproperty
    a_irq: assert property (p_irq) else $error("clock interrupt missing");
endmodule

/* verification/alcb_ctrl_model.sv */
// Purpose: System controller and channel master stand-in driving the block's control pins
// Assumes: One strobe pulse per bus cycle; commands held by the bench
// Notes:   Cycle kind 0 I/O, 1 memory, 2 DMA, 3 refresh
`timescale 1ns/10ps
module alcb_ctrl_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [1:0] kind,
    input  wire logic       onboard,
    input  wire logic       takeBus,
    input  wire logic       addrBit20Raw,
    output logic            addrLatchStrobe,
    output logic            commandBufferEnableN,
    output logic            addressEnable,
    output logic            masterRequestN,
    output logic            dmaRequest,
    output logic            addressBitTwenty,
    output logic            busy
);
    logic [2:0] cnt_r;

    assign busy             = (cnt_r != 3'h0);
    assign masterRequestN   = ~takeBus;
    assign dmaRequest       = takeBus;
    assign addressBitTwenty = addrBit20Raw;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cnt_r                <= 3'h0;
            addrLatchStrobe      <= 1'b0;
            commandBufferEnableN <= 1'b1;
            addressEnable        <= 1'b0;
        end
        else if (start && !busy)
        begin
            cnt_r                <= 3'h6;
            addrLatchStrobe      <= 1'b1;
            // On-board I/O and memory targets keep channel commands off to avoid contention
            commandBufferEnableN <= ~(kind[1] | ~onboard);
            addressEnable        <= kind[1];
        end
        else if (busy)
        begin
            cnt_r           <= cnt_r - 3'h1;
            addrLatchStrobe <= 1'b0;
            if (cnt_r == 3'h1)
            begin
                commandBufferEnableN <= 1'b1;
                addressEnable        <= 1'b0;
            end
        end
    end
endmodule

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the address latch and command buffer block
// Assumes: Zero-wait AHB slave; SECOND_CYCLES shortened to 4
// Notes:   Pin checks run 1 ns after an edge so registered outputs have landed; read data is taken at the edge after its data phase
`timescale 1ns/10ps
module tb_top;
    logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, start = 1'b0, onboard = 1'b0, takeBus = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00, kind = 2'b00;
    logic [2:0] hsize = 3'b010, progIoSelectN;
    logic [31:0] hwdata = 32'h0, hrdata, q, r, a, b, rng = 32'h084d;
    logic [23:0] cpuAddrIn = 24'h0, cpuAddrOut, base [3];
    logic bheIn = 1'b1, ioRdN = 1'b1, ioWrN = 1'b1, memRdN = 1'b1, memWrN = 1'b1, chBheIn = 1'b1;
    logic chRdN = 1'b1, chWrN = 1'b1, hreadyout, hresp, cpuAddrOe, cpuBheOutN, cpuBheOe, cpuCmdOe;
    logic strobe, cbeN, aen, mreqN, a20, busy, chAddrOe, chBheOutN, chBheOe, chIoOe, memRdOutN, memWrOutN;
    logic mxN, minuteOut, irq, nmiDisable, testMode, chIoRdOutN, chIoWrOutN;
    logic [3:0] cpuCmdOutN;
    logic [16:0] chAddrIn = 17'h0, chLow;
    logic [2:0] chMid;
    logic [6:0] upper, ix [4] = '{7'h00, 7'h3f, 7'h40, 7'h7f};
    logic [7:0] dat [4];
    int bad_count = 0, checked = 0, n;

    always #5 clock = ~clock;

    alcb_ctrl_model u_alcb_ctrl_model (.clock(clock), .rst(rst), .start(start), .kind(kind), .onboard(onboard),
        .takeBus(takeBus), .addrBit20Raw(cpuAddrIn[20]), .addrLatchStrobe(strobe), .commandBufferEnableN(cbeN),
        .addressEnable(aen), .masterRequestN(mreqN), .dmaRequest(), .addressBitTwenty(a20), .busy(busy));

    alcb_top #(.SECOND_CYCLES(4)) u_alcb_top (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpuAddrIn(cpuAddrIn), .cpuAddrOut(cpuAddrOut), .cpuAddrOe(cpuAddrOe),
        .addressBitTwenty(a20), .cpuByteHighEnableInN(bheIn), .cpuByteHighEnableOutN(cpuBheOutN),
        .cpuByteHighEnableOe(cpuBheOe), .cpuIoReadN(ioRdN), .cpuIoWriteN(ioWrN), .cpuMemReadN(memRdN),
        .cpuMemWriteN(memWrN), .cpuCmdOutN(cpuCmdOutN), .cpuCmdOe(cpuCmdOe), .addrLatchStrobe(strobe),
        .commandBufferEnableN(cbeN), .addressEnable(aen), .channelAddrLowIn(chAddrIn),
        .channelLatchedAddressLow(chLow), .channelAddrLowOe(chAddrOe), .channelLatchedAddressMid(chMid),
        .upperUnlatchedAddress(upper), .channelByteHighEnableInN(chBheIn), .channelByteHighEnableOutN(chBheOutN),
        .channelByteHighEnableOe(chBheOe), .masterRequestN(mreqN), .channelIoReadInN(chRdN),
        .channelIoWriteInN(chWrN), .channelIoReadOutN(chIoRdOutN), .channelIoWriteOutN(chIoWrOutN),
        .channelIoOe(chIoOe), .lowmegChannelMemReadN(memRdOutN), .lowmegChannelMemWriteN(memWrOutN),
        .memaddrTransceiverEnableN(mxN), .minutePulseOut(minuteOut), .clockInterruptRequest(irq),
        .nmiDisable(nmiDisable), .testMode(testMode), .progIoSelectN(progIoSelectN));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Bounded waits: a hang counts as a mismatch and ends the run
    task automatic waitReady();
        n = 0;
        do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 64);
        if (n >= 64)
        begin
            bad_count++;
            results();
        end
    endtask

    task automatic waitIdle();
        n = 0;
        do @(posedge clock); while (busy !== 1'b0 && ++n < 64);
        if (n >= 64)
        begin
            bad_count++;
            results();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= ad;
        hwrite <= wr;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        waitReady();
        q = hrdata;
    endtask

    task automatic rdChk(input string nm, input logic [7:0] ad, input logic [31:0] exp);
        ahb(1'b0, ad, 32'h0);
        chk(nm, q, exp);
    endtask

    task automatic busCycle(input logic [1:0] k, input logic onb, input logic [23:0] ad);
        @(posedge clock);
        cpuAddrIn <= ad;
        kind <= k;
        onboard <= onb;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        settle(1);
        chk("bus", {hreadyout, hresp, nmiDisable, testMode, progIoSelectN}, 7'b1010111);
        chk("idleN", {memRdOutN, memWrOutN, mxN}, 3'b111);
        rdChk("index", alcb_pkg::OFS_INDEX, 32'h80);
        rdChk("ctrl", alcb_pkg::OFS_CTRL, 32'h0);
        rdChk("cs0", alcb_pkg::OFS_CS0, 32'h0);
        rdChk("mcport", alcb_pkg::OFS_MCPORT, 32'h22);
        rdChk("unmapped", 8'h40, 32'h0);
        $display("test reset done");

        for (int m = 0; m < 6; m++)
        begin
            ahb(1'b1, alcb_pkg::OFS_CTRL, 32'(m % 3));
            a = rnd();
            b = rnd();
            bheIn <= a[24];
            busCycle(2'd0, 1'b0, a[23:0]);
            cpuAddrIn <= b[23:0];
            bheIn <= ~a[24];
            settle(2);
            chk("low", chLow, a[16:0]);
            chk("mid", chMid, a[19:17]);
            chk("upper", upper, (m % 3 == 0) ? b[23:17] : a[23:17]);
            chk("bhe", chBheOutN, a[24]);
            waitIdle();
        end
        $display("test latch done");

        ahb(1'b1, alcb_pkg::OFS_CTRL, 32'h3c);
        for (int i = 0; i < 3; i++)
        begin
            r = rnd();
            base[i] = r[23:0];
            ahb(1'b1, alcb_pkg::OFS_CS0 + 8'(4 * i), {8'h0, base[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            ioRdN <= 1'b0;
            busCycle((i == 3) ? 2'd2 : 2'd0, 1'b0, base[i % 3]);
            cpuAddrIn <= ~base[i % 3];
            settle(2);
            chk("sel", progIoSelectN, (i == 3) ? 3'b111 : 3'(~(3'b001 << i)));
            chk("ioOe", {chIoOe, chIoRdOutN, chIoWrOutN}, 3'b101);
            waitIdle();
        end
        ioRdN <= 1'b0;
        busCycle(2'd0, 1'b1, 24'h000022);
        settle(2);
        chk("mx", mxN, 1'b0);
        chk("ioOeOnboard", chIoOe, 1'b0);
        waitIdle();
        ioRdN <= 1'b1;
        $display("test select done");

        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            memRdN <= (i % 2 == 1);
            memWrN <= (i % 2 == 0);
            busCycle(2'd1, 1'b0, (i < 2) ? (r[23:0] & 24'h0fffff) : (r[23:0] | 24'h100000));
            settle(2);
            chk("mrd", memRdOutN, (i == 0) ? 1'b0 : 1'b1);
            chk("mwr", memWrOutN, (i == 1) ? 1'b0 : 1'b1);
            waitIdle();
        end
        memRdN <= 1'b1;
        memWrN <= 1'b1;
        $display("test lowmeg done");

        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            dat[i] = r[7:0];
            ahb(1'b1, alcb_pkg::OFS_INDEX, {24'h0, r[8], ix[i]});
            settle(1);
            chk("nmi", nmiDisable, r[8]);
            ahb(1'b1, alcb_pkg::OFS_DATA, {24'h0, dat[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b1, alcb_pkg::OFS_INDEX, {25'h0, ix[i]});
            rdChk("cmos", alcb_pkg::OFS_DATA, {24'h0, dat[i]});
        end
        $display("test cmos done");

        r = rnd();
        chAddrIn <= r[16:0];
        chBheIn <= r[17];
        takeBus <= 1'b1;
        settle(3);
        chk("addrOut", {cpuAddrOe, chAddrOe, cpuAddrOut}, {2'b10, 7'h0, r[16:0]});
        chk("bheOut", {cpuBheOe, chBheOe, cpuBheOutN}, {2'b10, r[17]});
        chk("noTest", testMode, 1'b0);
        @(posedge clock);
        chRdN <= 1'b0;
        chWrN <= 1'b0;
        settle(2);
        chk("test", testMode, 1'b1);
        chk("cmd", {cpuCmdOe, cpuCmdOutN}, 5'b10011);
        ahb(1'b0, alcb_pkg::OFS_STATUS, 32'h0);
        chk("status", {q[2], q[0]}, 2'b11);
        chRdN <= 1'b1;
        chWrN <= 1'b1;
        takeBus <= 1'b0;
        settle(3);
        chk("testOff", testMode, 1'b0);
        $display("test master done");

        for (int p = 0; p < 2; p++)
        begin
            n = 0;
            do settle(1); while (minuteOut !== 1'b1 && ++n < 300);
            chk("minuteGap", (p == 0 && n < 300) ? 60 * 4 : n + 1, 60 * 4);
        end
        settle(1);
        chk("irq", irq, 1'b1);
        ahb(1'b1, alcb_pkg::OFS_STATUS, 32'h2);
        ahb(1'b0, alcb_pkg::OFS_STATUS, 32'h0);
        chk("flagClear", q[1], 1'b0);
        $display("test minute done");
        results();
    end
endmodule
